// ### hw/tone_alert_pkg.sv
// shared constants, register map and carrier types of the tone alert generator
`default_nettype none
package tone_alert_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PERIOD_W = 16;
  localparam int REPEAT_W = 6;

  // ************************************************************
  // rates: core clock and counting reference, in MHz
  // ************************************************************
  localparam logic [7:0] CORE_MHZ = 8'hc8;
  localparam logic [7:0] REF_MHZ = 8'h0d;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_THRES = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REPEAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PCOUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [PERIOD_W-1:0] THRES_RST = 16'h0000;
  localparam logic [REPEAT_W-1:0] REPEAT_RST = 6'h3f;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int CLK_LSB = 0;
  localparam int MODE_LSB = 2;
  localparam int SRC_BIT = 8;

  // ************************************************************
  // prescaler masks for divide by 1, 2, 4, 8
  // ************************************************************
  localparam logic [2:0] DIV1_MASK = 3'h0;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_INVERT = 2'b00,
    MODE_GATE = 2'b01,
    MODE_PLAIN = 2'b10,
    MODE_SPARE = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    DIV_BY1 = 2'b00,
    DIV_BY2 = 2'b01,
    DIV_BY4 = 2'b10,
    DIV_BY8 = 2'b11
  } div_t;

  typedef struct packed {
    logic source;
    mode_t mode;
    div_t clk_sel;
  } ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage
`default_nettype wire

// ### hw/tone_tick_divider.sv
// counting tick generator: 13 MHz reference enable with selectable divider
`timescale 1ns/1ps
`default_nettype none
module tone_tick_divider (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // divider selection
  input wire tone_alert_pkg::div_t div_sel_in,
  // counting tick, one cycle
  output logic tick_out
);
  import tone_alert_pkg::*;

  logic [7:0] acc;
  logic [7:0] next_acc;
  logic ref_hit;
  logic [2:0] pre;
  logic [2:0] mask;

  // fractional accumulator: average rate is exact, jitter is one core cycle
  always_comb begin
    next_acc = acc + REF_MHZ;
    ref_hit = 1'b0;
    if (next_acc >= CORE_MHZ) begin
      next_acc = next_acc - CORE_MHZ;
      ref_hit = 1'b1;
    end
  end

  always_comb begin
    case (div_sel_in)
      DIV_BY1: mask = DIV1_MASK;
      DIV_BY2: mask = DIV2_MASK;
      DIV_BY4: mask = DIV4_MASK;
      default: mask = DIV8_MASK;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      acc <= 8'h00;
      pre <= 3'h0;
      tick_out <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_out <= ref_hit && ((pre & mask) == mask); // RL8
      if (ref_hit) begin
        pre <= pre + 3'h1;
      end
    end
  end

  a_tick_gap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RL8
    tick_out |=> (!tick_out) [*8])
    else $error("counting ticks closer than the reference period");

endmodule
`default_nettype wire

// ### hw/tone_reload_counter.sv
// down-counter that reloads from its reload value on the tick after zero
`timescale 1ns/1ps
`default_nettype none
module tone_reload_counter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic restart_in,
  input wire logic step_in,
  input wire logic [WIDTH-1:0] reload_in,
  // state
  output logic [WIDTH-1:0] count_out,
  output logic zero_out
);

  assign zero_out = (count_out == '0);

  // the reload value is only sampled at zero or on restart, so a write never cuts a run short
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count_out <= RESET_VALUE;
    end else if (restart_in) begin
      count_out <= reload_in;
    end else if (step_in) begin
      if (zero_out) begin
        count_out <= reload_in; // RL15
      end else begin
        count_out <= count_out - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/tone_alert_pwm.sv
// tone alert generator: register file, nested counters and output shaping
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: source bit 0 sends the PWM waveform out, 1 sends the PDM input.
// RL2: power-off input high holds the alert output low.
// RL3: base level is low when period count >= threshold, high when below.
// RL4: first mode inverts the base level each time the repeat count hits zero.
// RL5: second mode alternates base waveform and forced low at each repeat zero.
// RL6: third mode ignores the repeat counter and follows the base level.
// RL7: mode field 00, 01, 10 select first, second, third mode.
// RL8: clock field picks 13 MHz divided by 1, 2, 4 or 8.
// RL9: repeat counter steps down once each time the period counter hits zero.
// RL10: both counters load from their reload registers.
// RL11: a period reload write takes effect only after the next zero.
// RL12: period counter and reload are 16 bits, repeat ones 6 bits.
// RL13: first two modes give 13 MHz over 2*div*(period+1)*(repeat+1).
// RL14: high-time fraction is threshold over period reload plus one.
// RL15: each counter reloads on the counting tick after reaching zero.
// RL16: mode field 11 behaves as the third mode.
module tone_alert_pwm (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire tone_alert_pkg::reg_req_t reg_req_in,
  output logic [tone_alert_pkg::DATA_W-1:0] read_data_out,
  // alert sources and control
  input wire logic pdm_in,
  input wire logic power_off_input_in,
  // alert pin
  output logic alert_out
);
  import tone_alert_pkg::*;

  // ************************************************************
  // register file
  // ************************************************************
  logic [PERIOD_W-1:0] period_reload_value;
  logic [PERIOD_W-1:0] duty_threshold_value;
  logic [REPEAT_W-1:0] repeat_reload_value;
  ctrl_t tone_control;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] next_read;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      period_reload_value <= PERIOD_RST;
      duty_threshold_value <= THRES_RST;
      repeat_reload_value <= REPEAT_RST;
      tone_control <= '0;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == OFS_PERIOD) begin
        period_reload_value <= reg_req_in.wdata; // RL11
      end else if (reg_req_in.addr == OFS_THRES) begin
        duty_threshold_value <= reg_req_in.wdata;
      end else if (reg_req_in.addr == OFS_REPEAT) begin
        repeat_reload_value <= reg_req_in.wdata[REPEAT_W-1:0]; // RL12
      end else if (reg_req_in.addr == OFS_CTRL) begin
        tone_control.clk_sel <= div_t'(reg_req_in.wdata[CLK_LSB+1:CLK_LSB]);
        tone_control.mode <= mode_t'(reg_req_in.wdata[MODE_LSB+1:MODE_LSB]); // RL7
        tone_control.source <= reg_req_in.wdata[SRC_BIT];
      end
    end
  end

  // unused control bits read as zero
  always_comb begin
    ctrl_word = DATA_ZERO;
    ctrl_word[CLK_LSB+1:CLK_LSB] = tone_control.clk_sel;
    ctrl_word[MODE_LSB+1:MODE_LSB] = tone_control.mode;
    ctrl_word[SRC_BIT] = tone_control.source;
  end

  // ************************************************************
  // counting tick and nested counters
  // ************************************************************
  logic tick;
  logic [PERIOD_W-1:0] period_count;
  logic [REPEAT_W-1:0] repeat_count;
  logic period_zero;
  logic repeat_zero;
  logic repeat_step;
  logic phase;

  tone_tick_divider divider (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .div_sel_in(tone_control.clk_sel),
    .tick_out(tick)
  );

  // power-off restarts both counters so a tone always begins with a full period
  tone_reload_counter #(
    .WIDTH(PERIOD_W),
    .RESET_VALUE(PERIOD_RST)
  ) period_counter (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .restart_in(power_off_input_in),
    .step_in(tick),
    .reload_in(period_reload_value), // RL10
    .count_out(period_count),
    .zero_out(period_zero)
  );

  assign repeat_step = tick && period_zero; // RL9

  tone_reload_counter #(
    .WIDTH(REPEAT_W),
    .RESET_VALUE(REPEAT_RST)
  ) repeat_counter (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .restart_in(power_off_input_in),
    .step_in(repeat_step),
    .reload_in(repeat_reload_value), // RL10
    .count_out(repeat_count),
    .zero_out(repeat_zero)
  );

  // phase flips once per (period+1)*(repeat+1) ticks, halving the tone rate
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      phase <= 1'b0;
    end else if (power_off_input_in) begin
      phase <= 1'b0;
    end else if (repeat_step && repeat_zero) begin
      phase <= !phase; // RL13
    end
  end

  // ************************************************************
  // output shaping
  // ************************************************************
  logic base_level;
  logic pwm_level;
  logic next_alert;

  // high fraction is threshold / (period reload + 1)
  assign base_level = (period_count < duty_threshold_value); // RL3 RL14

  always_comb begin
    case (tone_control.mode)
      MODE_INVERT: pwm_level = base_level ^ phase; // RL4
      MODE_GATE: pwm_level = base_level && !phase; // RL5
      MODE_PLAIN: pwm_level = base_level; // RL6
      default: pwm_level = base_level; // RL16
    endcase
  end

  always_comb begin
    if (power_off_input_in) begin
      next_alert = 1'b0; // RL2
    end else if (tone_control.source) begin
      next_alert = pdm_in; // RL1
    end else begin
      next_alert = pwm_level; // RL1
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= next_alert;
    end
  end

  // ************************************************************
  // read path: data stand in the cycle after the strobe only
  // ************************************************************
  always_comb begin
    next_read = DATA_ZERO;
    if (reg_req_in.rd) begin
      if (reg_req_in.addr == OFS_PERIOD) begin
        next_read = period_reload_value;
      end else if (reg_req_in.addr == OFS_THRES) begin
        next_read = duty_threshold_value;
      end else if (reg_req_in.addr == OFS_REPEAT) begin
        next_read[REPEAT_W-1:0] = repeat_reload_value;
      end else if (reg_req_in.addr == OFS_CTRL) begin
        next_read = ctrl_word;
      end else if (reg_req_in.addr == OFS_PCOUNT) begin
        next_read = period_count;
      end else if (reg_req_in.addr == OFS_STATUS) begin
        next_read[REPEAT_W-1:0] = repeat_count;
        next_read[REPEAT_W] = phase;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      read_data_out <= DATA_ZERO;
    end else begin
      read_data_out <= next_read;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_power_off_low: assert property ( // RL2
    @(posedge core_clk_in) disable iff (sys_rst_in)
    power_off_input_in |=> !alert_out)
    else $error("alert output not low while powered off");

  a_pdm_route: assert property ( // RL1
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tone_control.source) |=> (alert_out == $past(pdm_in)))
    else $error("pdm source not routed to the alert output");

  a_plain_mode: assert property ( // RL6
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source && tone_control.mode == MODE_PLAIN)
    |=> (alert_out == ($past(period_count) < $past(duty_threshold_value))))
    else $error("third mode output differs from threshold compare");

  a_spare_mode: assert property ( // RL16
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source && tone_control.mode == MODE_SPARE)
    |=> (alert_out == $past(base_level)))
    else $error("mode 11 output differs from plain compare");

  a_invert_mode: assert property ( // RL4
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source && tone_control.mode == MODE_INVERT)
    |=> (alert_out == ($past(base_level) ^ $past(phase))))
    else $error("first mode polarity wrong");

  a_gate_mode: assert property ( // RL5
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source && tone_control.mode == MODE_GATE)
    |=> (alert_out == ($past(base_level) && !$past(phase))))
    else $error("second mode gating wrong");

  // a power-off in the cycle after the flip clears the phase, which is not a fault
  a_phase_flip: assert property ( // RL4
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tick && period_zero && repeat_zero)
    |=> (phase != $past(phase)) ##1 ($stable(phase) || $past(power_off_input_in)))
    else $error("phase did not flip on repeat zero");

  a_repeat_step: assert property ( // RL9
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tick && period_zero && !repeat_zero)
    |=> (repeat_count == ($past(repeat_count) - 6'h01)))
    else $error("repeat counter did not step on period zero");

  a_repeat_hold: assert property ( // RL9
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !(tick && period_zero)) |=> $stable(repeat_count))
    else $error("repeat counter moved without period zero");

  a_period_reload: assert property ( // RL15
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tick && period_zero)
    |=> (period_count == $past(period_reload_value)))
    else $error("period counter did not reload after zero");

  a_period_write: assert property ( // RL11
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tick && !period_zero)
    |=> (period_count == ($past(period_count) - 16'h0001)))
    else $error("period countdown disturbed");

  a_ctrl_read: assert property ( // RL7
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (reg_req_in.rd && reg_req_in.addr == OFS_CTRL) |=> (read_data_out == $past(ctrl_word)))
    else $error("control readback wrong");

  a_repeat_reload: assert property ( // RL15
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && tick && period_zero && repeat_zero)
    |=> (repeat_count == $past(repeat_reload_value)))
    else $error("repeat counter did not reload after zero");

  a_period_idle: assert property ( // RL8
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tick) |=> $stable(period_count))
    else $error("period counter moved without a counting tick");

  a_power_restart: assert property ( // RL10
    @(posedge core_clk_in) disable iff (sys_rst_in)
    power_off_input_in
    |=> (period_count == $past(period_reload_value))
    && (repeat_count == $past(repeat_reload_value)) && !phase)
    else $error("counters not restarted from their reload values");

  a_phase_hold: assert property ( // RL4
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !(tick && period_zero && repeat_zero)) |=> $stable(phase))
    else $error("phase moved without a repeat zero");

  a_threshold_low: assert property ( // RL3
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source && tone_control.mode == MODE_PLAIN
    && period_count >= duty_threshold_value) |=> !alert_out)
    else $error("output high although period count reached the threshold");

  a_pwm_route: assert property ( // RL1
    @(posedge core_clk_in) disable iff (sys_rst_in)
    (!power_off_input_in && !tone_control.source) |=> (alert_out == $past(pwm_level)))
    else $error("pwm waveform not routed to the alert output");

endmodule
`default_nettype wire

// ### verification/buzzer_stage_model.sv
// far-side model: buzzer driver stage that counts pulses and on-time
`timescale 1ns/1ps
`default_nettype none
module buzzer_stage_model (
  // clock
  input wire logic core_clk_in,
  // pin and window control
  input wire logic drive_in,
  input wire logic clear_in,
  // counts since the last clear
  output logic [31:0] rises_out,
  output logic [31:0] on_cycles_out
);
  logic last;
  // a driver stage reacts to edges; on-time gives the heard volume
  always_ff @(posedge core_clk_in) begin
    last <= drive_in;
    if (clear_in) begin
      rises_out <= '0;
      on_cycles_out <= '0;
    end else begin
      rises_out <= rises_out + {31'h0, drive_in & ~last};
      on_cycles_out <= on_cycles_out + {31'h0, drive_in};
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench of the tone alert generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tone_alert_pkg::*;
  // ************************************************************
  // stimulus and observation
  // ************************************************************
  localparam int WIN = 6000;
  localparam int TICKS = 390;
  localparam int LIMIT = 90000;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic pdm = 1'b0;
  logic pwr_off = 1'b0;
  logic alert;
  logic clr = 1'b1;
  logic [31:0] rises;
  logic [31:0] on_cycles;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2.5 core_clk_in = ~core_clk_in;

  tone_alert_pwm DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .read_data_out(rdata), .pdm_in(pdm), .power_off_input_in(pwr_off), .alert_out(alert));
  buzzer_stage_model buzzer (.core_clk_in(core_clk_in), .drive_in(alert), .clear_in(clr),
    .rises_out(rises), .on_cycles_out(on_cycles));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hang counts as a failure
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req <= '0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: DATA_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                            input string w);
    logic [DATA_W-1:0] d;
    reg_read(a, d);
    check({16'h0, d}, {16'h0, e}, w);
  endtask

  task automatic cfg(input logic [15:0] p, input logic [15:0] t, input logic [15:0] r,
                     input logic [15:0] c);
    reg_write(OFS_PERIOD, p);
    reg_write(OFS_THRES, t);
    reg_write(OFS_REPEAT, r);
    reg_write(OFS_CTRL, c);
  endtask

  // power-off pulse restarts counters so every window starts from the same phase
  task automatic measure(output int r, output int h);
    @(posedge core_clk_in);
    pwr_off <= 1'b1;
    clr <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    pwr_off <= 1'b0;
    clr <= 1'b0;
    repeat (WIN) @(posedge core_clk_in);
    #1 r = int'(rises);
    h = int'(on_cycles);
  endtask

  function automatic logic [31:0] near(input int got, input int exp, input int tol);
    return {31'h0, (got >= exp - tol) && (got <= exp + tol)};
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs;
    logic [DATA_W-1:0] d;
    expect_reg(OFS_PERIOD, PERIOD_RST, "period reset");
    expect_reg(OFS_THRES, THRES_RST, "threshold reset");
    expect_reg(OFS_REPEAT, 16'h003f, "repeat reset");
    expect_reg(OFS_CTRL, DATA_ZERO, "control reset");
    expect_reg(8'h20, DATA_ZERO, "unmapped read");
    reg_write(OFS_PERIOD, 16'h0005);
    reg_read(OFS_PCOUNT, d);
    check({31'h0, d > 16'hff00}, 32'h1, "countdown disturbed");
    expect_reg(OFS_PERIOD, 16'h0005, "period readback");
    reg_write(OFS_REPEAT, 16'hffff);
    expect_reg(OFS_REPEAT, 16'h003f, "repeat width");
  endtask

  task automatic t_pdm_off;
    logic [15:0] v;
    v = 16'hb4e1;
    cfg(16'h0001, 16'h0000, 16'h0001, 16'h0108);
    expect_reg(OFS_CTRL, 16'h0108, "control readback");
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_in);
      pdm <= v[i];
      #1;
      if (i > 0) check({31'h0, alert}, {31'h0, v[i-1]}, "pdm path");
    end
    @(posedge core_clk_in);
    pdm <= 1'b1;
    pwr_off <= 1'b1;
    repeat (40) begin
      @(posedge core_clk_in);
      #1 check({31'h0, alert}, 32'h0, "alert while off");
    end
    expect_reg(OFS_PCOUNT, 16'h0001, "period restart");
    expect_reg(OFS_STATUS, 16'h0001, "repeat restart");
    @(posedge core_clk_in);
    pwr_off <= 1'b0;
    pdm <= 1'b0;
  endtask

  // threshold 1 over period 1: rises per 8 ticks differ by mode
  task automatic t_modes;
    int r;
    int h;
    int k[4] = '{3, 2, 4, 4};
    for (int m = 0; m < 4; m++) begin
      cfg(16'h0001, 16'h0001, 16'h0001, 16'(m << 2));
      measure(r, h);
      check(near(r, TICKS * k[m] / 8, 3), 32'h1, "mode waveform");
    end
  endtask

  // threshold 0 in the first mode leaves the phase square wave alone
  task automatic t_divider;
    int r;
    int h;
    for (int c = 0; c < 4; c++) begin
      cfg(16'h0001, 16'h0000, 16'h0001, 16'(c));
      measure(r, h);
      check(near(r, (TICKS / (1 << c) + 4) / 8, 1), 32'h1, "tone rate");
    end
  endtask

  task automatic t_volume;
    int r;
    int h;
    for (int t = 0; t <= 4; t += 2) begin
      cfg(16'h0003, 16'(t), 16'h0001, 16'h0008);
      measure(r, h);
      check(near(h, WIN * t / 4, (t == 2) ? 40 : 2), 32'h1, "on time");
    end
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_pdm_off();
    t_modes();
    t_divider();
    t_volume();
    close_out();
  end
endmodule
`default_nettype wire
